// File: design/fault_status_pkg.sv
/*
 fault_status_pkg: register indices, field positions, reset values and
 timing counts for the fault-status and serial-monitor block.
 Assumes a 25 MHz core clock; all users import the whole package.
*/
package fault_status_pkg;
    // frame layout: 3 address bits above 13 data bits
    localparam int FRAME_BITS = 16;
    localparam int DATA_BITS = 13;
    localparam int ADDR_MSB = 15;
    localparam int ADDR_LSB = 13;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_SAT = 5'h11;
    localparam logic [CNT_W-1:0] CNT_GOOD = 5'h10;
    // number of leading response bits that carry the fault summary
    localparam int FAULT_LEAD = 3;

    // register indices as addressed in the frame
    localparam logic [2:0] REG3_IDX = 3'h3;
    localparam logic [2:0] REG4_IDX = 3'h4;
    localparam logic [2:0] REG5_IDX = 3'h5;
    localparam logic [2:0] REG6_IDX = 3'h6;
    localparam logic [2:0] FAULT_STATUS_IDX = 3'h7;

    // fault_status fields
    localparam int FS_OC_LSB = 0;
    localparam int FS_OC_MSB = 7;
    localparam int FS_SUPPLY_LOW = 8;
    localparam int FS_SUPPLY_HIGH = 9;
    localparam int FS_TEMP_WARN = 10;
    localparam int FS_TEMP_SHUT = 11;
    localparam int FS_CLEAR = 12;
    localparam logic [11:0] FS_RESET = 12'h000;

    // register 3..6 fields
    localparam int R3_PIN_DISABLE = 5;
    localparam int R3_THR_LSB = 6;
    localparam int R3_THR_MSB = 7;
    localparam int R45_THR_LSB = 5;
    localparam int R45_THR_MSB = 7;
    localparam int R6_OPEN_A = 5;
    localparam int R6_OPEN_B = 6;
    localparam int R6_REF_ERR = 7;
    localparam int R6_STALL = 8;
    localparam int R6_MIRROR_SEL = 11;
    localparam int R6_CLEAR = 12;
    localparam logic [12:0] R6_WMASK = 13'h0E1F;
    localparam logic [12:0] REG_RESET = 13'h0000;

    // stall threshold unit time and its cycle count
    localparam int CLK_PERIOD_NS = 40;
    localparam int STALL_UNIT_NS = 16000;
    localparam int STALL_UNIT_CYC = STALL_UNIT_NS / CLK_PERIOD_NS;
    localparam int UNIT_CNT_W = 9;
    localparam int THR_W = 8;
endpackage

// File: design/fault_status_spi_monitor.sv
/*
 fault_status_spi_monitor: latched fault flags, serial register port with
 frame-length check, summary fault level on the serial output, stall
 threshold compare and the pulse-width pin mux.
 Assumes fault and regulation inputs are synchronous to clk; the serial
 pins come from the host's clock domain and are synchronised here.
*/
// Functional notes
// - bits 7..0 latch overcurrent of each of the eight bridge transistors
// - bits 9..8 report supply state: 01 too low, 10 too high
// - bit 10 flags thermal warning only, outputs keep running
// - thermal shutdown sets bit 11 and holds bridges off until cleared
// - writing clear bit 12 zeroes every fault flag
// - summary fault drives data out from select falling edge to bit 12
// - summary is OR of open-load, reference error and fault bits 0..11
// - chip select rising edge moves shift register into addressed register
// - rising clocks counted per frame; write allowed only at exactly sixteen
// - frames with other clock counts are dropped, registers untouched
// - stall flag sets when quadrant on-time sum is below the threshold
// - mirror select zero routes bridge A regulation to the pulse pin
// - mirror select one routes the stall flag to the pulse pin
// - pulse pin is driven only while the pin-disable bit is zero
// - threshold counts in sixteen-microsecond units of on time
`timescale 1ns/100ps
`default_nettype none
module fault_status_spi_monitor
    import fault_status_pkg::*;
#(
    parameter int UNIT_CYC = STALL_UNIT_CYC
) (
    input wire logic clk, // core clock, 25 MHz
    input wire logic nrst, // async reset, active low
    input wire logic chip_select_n, // serial chip select pin
    input wire logic serial_clk, // serial clock pin
    input wire logic serial_data_in, // serial data pin in
    output logic serial_data_out, // serial data pin level
    output logic serial_data_out_oe, // serial data pin enable
    input wire logic [7:0] overcurrent_in, // per-transistor limit hit
    input wire logic supply_low_in, // supply undervoltage
    input wire logic supply_high_in, // supply overvoltage
    input wire logic temp_warn_in, // temperature warning reached
    input wire logic temp_shut_in, // thermal shutdown reached
    input wire logic open_load_a_in, // open load on bridge A
    input wire logic open_load_b_in, // open load on bridge B
    input wire logic ref_current_err_in, // reference current bad
    input wire logic regulation_a_in, // bridge A regulation signal
    input wire logic quadrant_active_in, // rising-current quadrant
    output logic pulse_pin_out, // pulse-width pin level
    output logic pulse_pin_oe, // pulse-width pin enable
    output logic bridges_off, // force all bridges off
    output logic [12:0] reg3_q, // register 3 contents
    output logic [12:0] reg4_q, // register 4 contents
    output logic [12:0] reg5_q, // register 5 contents
    output logic [12:0] reg6_q // register 6 writable contents
);
    typedef enum logic [1:0] {
        LINK_IDLE = 2'b00,
        LINK_FRAME = 2'b01,
        LINK_DONE = 2'b10
    } link_state_t;

    logic cs_n_s, sclk_s, sdi_s;
    logic cs_n_d_r, sclk_d_r;
    logic cs_fall, cs_rise, sclk_rise, sclk_fall;
    link_state_t state_r, state_nxt;
    logic [CNT_W-1:0] bit_cnt_r;
    logic [FRAME_BITS-1:0] rx_r;
    logic [FRAME_BITS-1:0] tx_r;
    logic [2:0] read_idx_r;
    logic frame_ok;
    logic [2:0] wr_idx;
    logic [DATA_BITS-1:0] wr_data;
    logic [11:0] fault_status_r;
    logic open_a_r, open_b_r, ref_err_r, stall_flag_r;
    logic fault_clear, reg6_clear;
    logic fault_summary;
    logic [DATA_BITS-1:0] read_data;
    logic [THR_W-1:0] stall_threshold;
    logic [UNIT_CNT_W-1:0] unit_cnt_r;
    logic [THR_W:0] on_sum_r;
    logic quad_d_r;
    logic quad_end;

    // serial pins come from the host domain
    sync2 #(.W(3), .INIT(3'h4)) u_pin_sync (
        .clk(clk),
        .nrst(nrst),
        .d({chip_select_n, serial_clk, serial_data_in}),
        .q({cs_n_s, sclk_s, sdi_s})
    );

    // edge detection on the synchronised copies
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cs_n_d_r <= 1'b1;
            sclk_d_r <= 1'b0;
        end else begin
            cs_n_d_r <= cs_n_s;
            sclk_d_r <= sclk_s;
        end
    end

    assign cs_fall = cs_n_d_r & ~cs_n_s;
    assign cs_rise = ~cs_n_d_r & cs_n_s;
    assign sclk_rise = ~sclk_d_r & sclk_s & ~cs_n_s;
    assign sclk_fall = sclk_d_r & ~sclk_s & ~cs_n_s;

    // frame sequencing
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            LINK_IDLE: begin
                if (cs_fall) begin
                    state_nxt = LINK_FRAME;
                end
            end
            LINK_FRAME: begin
                if (cs_rise) begin
                    state_nxt = LINK_DONE;
                end
            end
            LINK_DONE: begin
                state_nxt = LINK_IDLE;
            end
            default: begin
                state_nxt = LINK_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= LINK_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // rising clocks counted, saturating so long frames stay rejected
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bit_cnt_r <= '0;
        end else if (cs_fall) begin
            bit_cnt_r <= '0;
        end else if (sclk_rise && bit_cnt_r != CNT_SAT) begin
            bit_cnt_r <= bit_cnt_r + 1'b1;
        end
    end

    // receive shift register, msb first, sampled on rising clock
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_r <= '0;
        end else if (sclk_rise) begin
            rx_r <= {rx_r[FRAME_BITS-2:0], sdi_s};
        end
    end

    // write strobe only for a frame of exactly sixteen clocks
    assign frame_ok = (state_r == LINK_FRAME) && cs_rise
        && (bit_cnt_r == CNT_GOOD);
    assign wr_idx = rx_r[ADDR_MSB:ADDR_LSB];
    assign wr_data = rx_r[DATA_BITS-1:0];
    assign fault_clear = frame_ok && wr_idx == FAULT_STATUS_IDX
        && wr_data[FS_CLEAR];
    assign reg6_clear = frame_ok && wr_idx == REG6_IDX
        && wr_data[R6_CLEAR];

    // control registers; a rejected frame leaves them untouched
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg3_q <= REG_RESET;
            reg4_q <= REG_RESET;
            reg5_q <= REG_RESET;
            reg6_q <= REG_RESET;
            read_idx_r <= FAULT_STATUS_IDX;
        end else if (frame_ok) begin
            read_idx_r <= wr_idx;
            case (wr_idx)
                REG3_IDX: reg3_q <= wr_data;
                REG4_IDX: reg4_q <= wr_data;
                REG5_IDX: reg5_q <= wr_data;
                REG6_IDX: reg6_q <= wr_data & R6_WMASK;
                default: begin
                end
            endcase
        end
    end

    // sticky fault flags; a new event wins over a clear in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fault_status_r <= FS_RESET;
        end else begin
            fault_status_r <= (fault_clear ? FS_RESET : fault_status_r)
                | {temp_shut_in,
                   temp_warn_in,
                   supply_high_in, supply_low_in,
                   overcurrent_in};
        end
    end

    // shutdown persists through the latched flag, not the live input
    assign bridges_off = fault_status_r[FS_TEMP_SHUT];

    // register 6 status flags, cleared by its own clear bit
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            open_a_r <= 1'b0;
            open_b_r <= 1'b0;
            ref_err_r <= 1'b0;
        end else begin
            open_a_r <= (open_a_r & ~reg6_clear) | open_load_a_in;
            open_b_r <= (open_b_r & ~reg6_clear) | open_load_b_in;
            ref_err_r <= (ref_err_r & ~reg6_clear) | ref_current_err_in;
        end
    end

    assign fault_summary = (|fault_status_r) | open_a_r | open_b_r
        | ref_err_r;

    // answer data: last addressed register
    always_comb begin
        case (read_idx_r)
            REG3_IDX: read_data = reg3_q;
            REG4_IDX: read_data = reg4_q;
            REG5_IDX: read_data = reg5_q;
            REG6_IDX: read_data = reg6_q | {4'h0, stall_flag_r,
                ref_err_r, open_b_r, open_a_r, 5'h00};
            FAULT_STATUS_IDX: read_data = {1'b0, fault_status_r};
            default: read_data = '0;
        endcase
    end

    // transmit: fault level leads, then data from bit 12 downward
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_r <= '0;
        end else if (cs_fall) begin
            tx_r <= {{FAULT_LEAD{fault_summary}}, read_data};
        end else if (sclk_fall) begin
            tx_r <= {tx_r[FRAME_BITS-2:0], 1'b0};
        end
    end

    // pin only driven inside a frame, released as soon as select rises
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            serial_data_out <= 1'b0;
            serial_data_out_oe <= 1'b0;
        end else begin
            serial_data_out <= tx_r[FRAME_BITS-1];
            serial_data_out_oe <= ~cs_n_s && state_r == LINK_FRAME;
        end
    end

    // threshold bits are spread over three registers
    assign stall_threshold = {reg5_q[R45_THR_MSB:R45_THR_LSB],
        reg4_q[R45_THR_MSB:R45_THR_LSB],
        reg3_q[R3_THR_MSB:R3_THR_LSB]};

    // on-time summed in 16 us units over one rising quadrant
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            unit_cnt_r <= '0;
            on_sum_r <= '0;
            quad_d_r <= 1'b0;
        end else begin
            quad_d_r <= quadrant_active_in;
            if (!quadrant_active_in) begin
                unit_cnt_r <= '0;
                on_sum_r <= '0;
            end else if (regulation_a_in) begin
                if (unit_cnt_r == UNIT_CNT_W'(UNIT_CYC - 1)) begin
                    unit_cnt_r <= '0;
                    if (!on_sum_r[THR_W]) begin
                        on_sum_r <= on_sum_r + 1'b1;
                    end
                end else begin
                    unit_cnt_r <= unit_cnt_r + 1'b1;
                end
            end
        end
    end

    assign quad_end = quad_d_r & ~quadrant_active_in;

    // stall decided at quadrant end; set wins over register 6 clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stall_flag_r <= 1'b0;
        end else if (quad_end && on_sum_r < {1'b0, stall_threshold}) begin
            stall_flag_r <= 1'b1;
        end else if (reg6_clear) begin
            stall_flag_r <= 1'b0;
        end
    end

    // pulse pin mux and enable, registered to keep the pin glitch free
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pulse_pin_out <= 1'b0;
            pulse_pin_oe <= 1'b0;
        end else begin
            pulse_pin_out <= reg6_q[R6_MIRROR_SEL] ? stall_flag_r
                : regulation_a_in;
            pulse_pin_oe <= ~reg3_q[R3_PIN_DISABLE];
        end
    end
endmodule // fault_status_spi_monitor
`default_nettype wire

// File: design/sync2.sv
/*
 sync2: two-flop synchroniser for a bundle of independent levels.
 Assumes each bit is a slow level or a clock slower than clk/2.
*/
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk, // core clock
    input wire logic nrst, // async reset, active low
    input wire logic [W-1:0] d, // asynchronous inputs
    output logic [W-1:0] q // synchronised outputs
);
    logic [W-1:0] meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_r <= INIT;
            q <= INIT;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // sync2
`default_nettype wire

// File: tb/fs_checker.sv
/*
 fs_checker: port-level assertions for the fault-status serial monitor.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module fs_checker
    import fault_status_pkg::*;
#(
    parameter int UNIT_CYC = 400 // stall unit length in clocks
) (
    input wire logic clk, // core clock
    input wire logic nrst, // async reset, active low
    input wire logic chip_select_n, // serial select pin
    input wire logic serial_clk, // serial clock pin
    input wire logic serial_data_out, // data out level
    input wire logic serial_data_out_oe, // data out enable
    input wire logic temp_shut_in, // thermal shutdown input
    input wire logic regulation_a_in, // bridge A regulation
    input wire logic pulse_pin_out, // pulse pin level
    input wire logic pulse_pin_oe, // pulse pin enable
    input wire logic bridges_off, // bridges forced off
    input wire logic [12:0] reg3_q, // register 3
    input wire logic [12:0] reg4_q, // register 4
    input wire logic [12:0] reg5_q, // register 5
    input wire logic [12:0] reg6_q // register 6
);
    // one domain only, so clock and reset are given once
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // the pins pass two flops, so a few cycles of slack are allowed
    a_oe_idle_off: assert property (
        chip_select_n [*5] |-> !serial_data_out_oe)
        else $error("data out driven while deselected");
    a_oe_in_frame: assert property (
        !chip_select_n [*6] |-> serial_data_out_oe)
        else $error("data out not driven inside a frame");
    a_dout_holds: assert property (
        serial_clk [*4] |-> $stable(serial_data_out))
        else $error("data out moved while link clock high");
    a_regs_still: assert property (
        !chip_select_n [*5] |=> $stable({reg3_q, reg4_q, reg5_q, reg6_q}))
        else $error("register changed inside a frame");
    a_write_at_end: assert property (
        !$stable({reg3_q, reg4_q, reg5_q, reg6_q})
        |-> chip_select_n && $past(chip_select_n, 2))
        else $error("register changed away from select rise");
    a_shut_kills: assert property (
        temp_shut_in |-> ##[1:4] bridges_off)
        else $error("shutdown did not force bridges off");
    a_off_sticky: assert property (
        bridges_off && !chip_select_n |=> bridges_off)
        else $error("bridges released without a clear");
    a_clear_in_gap: assert property (
        $fell(bridges_off) |-> chip_select_n)
        else $error("bridges released inside a frame");
    a_pin_disable: assert property (
        reg3_q[R3_PIN_DISABLE] [*2] |-> !pulse_pin_oe)
        else $error("pulse pin driven while disabled");
    a_pin_enable: assert property (
        !reg3_q[R3_PIN_DISABLE] [*2] |-> pulse_pin_oe)
        else $error("pulse pin released while enabled");
    // the pin is registered, so the source must sit still a few cycles
    a_pin_follows: assert property (
        (!reg6_q[R6_MIRROR_SEL] && !reg3_q[R3_PIN_DISABLE]
        && $stable(regulation_a_in)) [*3]
        |-> pulse_pin_out == regulation_a_in)
        else $error("pulse pin does not follow regulation");
endmodule // fs_checker
`default_nettype wire

// File: tb/spi_host_model.sv
/*
 spi_host_model: behavioural serial host with its own select line.
 Assumes frames are started by task calls and spaced by the task itself.
*/
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
    output logic chip_select_n, // select, one per device
    output logic serial_clk, // link clock, idle low
    output logic serial_data_in, // command bits
    input wire logic serial_data_out, // response level
    input wire logic serial_data_out_oe // response enable
);
    // idle bus: deselected, clock low, data line pulled low
    initial begin
        chip_select_n = 1'b1;
        serial_clk = 1'b0;
        serial_data_in = 1'b0;
    end

    // n clocks at 320 ns, MSB first; the answer is taken late in the high
    // phase because the device updates only some cycles after a fall
    task automatic xfer(input logic [15:0] cmd, input int n,
                        output logic [15:0] rsp);
        #13 chip_select_n = 1'b0;
        #160;
        for (int i = 0; i < n; i++) begin
            serial_data_in = (i < 16) ? cmd[15-i] : 1'b0;
            #160 serial_clk = 1'b1;
            #150 rsp = {rsp[14:0], serial_data_out_oe ? serial_data_out : 1'bx};
            #10 serial_clk = 1'b0;
        end
        serial_data_in = 1'b0;
        #160 chip_select_n = 1'b1;
        #2200; // select high gap between frames
    endtask
endmodule // spi_host_model
`default_nettype wire

// File: tb/tb_top.sv
/*
 tb_top: self-checking bench for the fault-status serial monitor.
 Assumes the host model drives the serial pins; a queue-free integer model
 of the registers predicts the answer of every sixteen-clock frame.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, s) begin \
    n_checks++; \
    if ((s) !== (e)) begin \
        n_errors++; \
        $display("ERROR %s exp %0h got %0h", nm, (e), (s)); \
    end \
end
module tb_top
    import fault_status_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic cs_n, sclk, sdi, sdo, sdo_oe, ppo, ppo_oe, boff;
    logic reg_a = 1'b0;
    logic quad = 1'b0;
    logic [14:0] flt = '0;
    logic [12:0] r3, r4, r5, r6;
    int n_errors = 0;
    int n_checks = 0;
    int seed = 51489;
    int fs = 0;
    int f6 = 0;
    int ptr = 7;
    int rg[8];

    always #20 clk = ~clk;

    // short stall unit keeps quadrants brief
    fault_status_spi_monitor #(.UNIT_CYC(4)) uut (
        .clk(clk), .nrst(nrst), .chip_select_n(cs_n), .serial_clk(sclk),
        .serial_data_in(sdi), .serial_data_out(sdo),
        .serial_data_out_oe(sdo_oe), .overcurrent_in(flt[7:0]),
        .supply_low_in(flt[8]), .supply_high_in(flt[9]),
        .temp_warn_in(flt[10]), .temp_shut_in(flt[11]),
        .open_load_a_in(flt[12]), .open_load_b_in(flt[13]),
        .ref_current_err_in(flt[14]), .regulation_a_in(reg_a),
        .quadrant_active_in(quad), .pulse_pin_out(ppo),
        .pulse_pin_oe(ppo_oe), .bridges_off(boff), .reg3_q(r3),
        .reg4_q(r4), .reg5_q(r5), .reg6_q(r6));
    spi_host_model host (.chip_select_n(cs_n), .serial_clk(sclk),
        .serial_data_in(sdi), .serial_data_out(sdo),
        .serial_data_out_oe(sdo_oe));

    // what the device should show for a register
    function automatic int rdv(int a);
        if (a == 7)
            return fs;
        if (a == 6)
            return rg[6] | f6;
        return rg[a];
    endfunction

    // one frame, then model update and port comparison
    task automatic frame(int a, int d, int n);
        logic [15:0] r;
        int e;
        // align so no pin edge of the frame lands on a core clock edge
        @(posedge clk) #2;
        e = ((((fs & 12'hFFF) != 0) || ((f6 & 13'h00E0) != 0)) ? 7 : 0) << 13;
        e = e | rdv(ptr);
        host.xfer(16'((a << 13) | d), n, r);
        if (n == 16) begin
            `CHK("response", e, r)
            ptr = a;
            if (a == 7 && d[12])
                fs = 0;
            if (a == 6 && d[12])
                f6 = 0;
            if (a == 6)
                rg[6] = d & R6_WMASK;
            else if (a != 7)
                rg[a] = d;
        end
        `CHK("reg3", rg[3], r3)
        `CHK("reg4", rg[4], r4)
        `CHK("reg5", rg[5], r5)
        `CHK("reg6", rg[6], r6)
        `CHK("bridges_off", fs >> 11 & 1, boff)
    endtask

    // short fault pulse; the flag must outlive it
    task automatic hit(int m);
        @(posedge clk) #2 flt = 15'(m);
        repeat (3) @(posedge clk);
        #2 flt = '0;
        fs = fs | (m & 12'hFFF);
        f6 = f6 | ((m >> 12) << 5);
    endtask

    // one rising-current quadrant with regulation on for c cycles
    task automatic quarter(int c);
        @(posedge clk) #2 quad = 1'b1;
        reg_a = 1'b1;
        repeat (c) @(posedge clk);
        #2 reg_a = 1'b0;
        quad = 1'b0;
        repeat (6) @(posedge clk);
        #2;
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        #2 nrst = 1'b1;
        repeat (5) @(posedge clk);
        #2;
        `CHK("data out enable", 0, sdo_oe)
        `CHK("pulse enable", 1, ppo_oe)
        frame(7, 0, 16);
        // overcurrent as one random group, every other flag source once, read twice, then both clears
        for (int k = 0; k < 8; k++) begin
            hit(k == 0 ? (($random(seed) & 255) | 1) : 1 << (k + 7));
            frame(7, 0, 16);
            frame(7, 0, 16);
            frame(6, 13'h1000, 16);
            frame(7, 13'h1000, 16);
            frame(7, 0, 16);
        end
        frame(3, 13'h0ABC, 15);
        frame(3, 13'h0123, 17);
        for (int a = 3; a < 7; a++)
            frame(a, $random(seed) & 13'h1FFF, 16);
        frame(7, 0, 16);
        // threshold 5 units, stall mirrored to the pin
        frame(3, 13'h0040, 16);
        frame(4, 13'h0020, 16);
        frame(5, 13'h0000, 16);
        frame(6, 13'h0800, 16);
        quarter(40);
        `CHK("pulse pin", 0, ppo)
        quarter(8);
        f6 = f6 | 13'h0100;
        `CHK("pulse pin", 1, ppo)
        frame(7, 0, 16);
        frame(6, 13'h1000, 16);
        for (int v = 0; v < 2; v++) begin
            @(posedge clk) #2 reg_a = v[0];
            repeat (4) @(posedge clk);
            `CHK("pulse pin", v, ppo)
        end
        frame(3, 13'h0020, 16);
        `CHK("pulse enable", 0, ppo_oe)
        close_out();
    end

    // the sequence needs well under half of this span
    initial begin
        #2_000_000;
        n_errors++;
        close_out();
    end
endmodule // tb_top

bind fault_status_spi_monitor fs_checker #(.UNIT_CYC(UNIT_CYC)) chk (
    .clk(clk), .nrst(nrst), .chip_select_n(chip_select_n),
    .serial_clk(serial_clk), .serial_data_out(serial_data_out),
    .serial_data_out_oe(serial_data_out_oe), .temp_shut_in(temp_shut_in),
    .regulation_a_in(regulation_a_in), .pulse_pin_out(pulse_pin_out),
    .pulse_pin_oe(pulse_pin_oe), .bridges_off(bridges_off),
    .reg3_q(reg3_q), .reg4_q(reg4_q), .reg5_q(reg5_q), .reg6_q(reg6_q));
`default_nettype wire
